// [hw/dtm_pkg.sv]
// Contract
// - While enabled and out of standby, convert enabled channels in a loop unaided
// - Each conversion yields one 8-bit reading per channel
// - Latest readings are readable at any time, also during conversions
// - Sleep input inactive halts conversion until active again and wake-up done
// - Registers keep their contents while conversion is halted by sleep
// - Three banks share a 16-entry space; bank-select register picks the bank
// - Low offsets are shared registers, upper offsets are per-bank channel registers
// - Bank select resets to bank 0
// - Compare reading to overheat, high, low limits; set matching status bit
// - Exceeded status bits stay set until software clears them
// - Channel alarm event bit set while its high or low bit is set
// - Channel overheat event bit set while its overheat bit is set
// - Shutdown output active only with shutdown enable and overheat status
// - Alarm output active only with alarm enable and high or low status
// - SYS_MGMT_INTERRUPT output active when any event bit and its SYS_MGMT_INTERRUPT route bit are set
// - IRQ output active when any event bit and its IRQ route bit are set
// - Shutdown indication is one combined output or one per sensor
// - Event bits: r1 alarm, r1 overheat, r2 alarm, r2 overheat, local alarm, local overheat
// - Writing 1 clears a write-one-to-clear bit; writing 0 leaves it
// - Readings and limits are 8-bit two's complement, one degree per LSB
// - Standby bit suspends conversion; registers stay accessible and retained
package dtm_pkg;
    localparam int NUM_CH = 3;
    localparam int EVT_WIDTH = 6;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_EVT_STATUS = 4'h0;
    localparam logic [3:0] IDX_SMI_ROUTE = 4'h2;
    localparam logic [3:0] IDX_IRQ_ROUTE = 4'h4;
    localparam logic [3:0] IDX_CONFIG = 4'h8;
    localparam logic [3:0] IDX_BANK_SEL = 4'h9;
    localparam logic [3:0] IDX_CH_CFG_STATUS = 4'hA;
    localparam logic [3:0] IDX_CH_READING = 4'hB;
    localparam logic [3:0] IDX_CH_HIGH = 4'hC;
    localparam logic [3:0] IDX_CH_LOW = 4'hD;
    localparam logic [3:0] IDX_CH_OVERHEAT = 4'hE;
    // Channel config/status fields
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_LOW_BIT = 1;
    localparam int CFG_HIGH_BIT = 2;
    localparam int CFG_OVER_BIT = 3;
    localparam int CFG_ALARM_EN_BIT = 4;
    localparam int CFG_SHUT_EN_BIT = 5;
    // Global config fields
    localparam int CONFIG_STANDBY_BIT = 0;
    localparam int CONFIG_COMBINED_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_HIGH = 8'h7F;
    localparam logic [7:0] RST_LOW = 8'hC9;
    localparam logic [7:0] RST_OVERHEAT = 8'h7F;
    localparam logic [7:0] RST_READING = 8'h00;
    localparam logic [1:0] RST_CONFIG = 2'h0;
    localparam logic [1:0] RST_BANK = 2'h0;
    // Wake-up delay after sleep input returns active
    localparam int CLK_PERIOD_NS = 4;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dtm_pkg

// [hw/dtm_channel.sv]
`timescale 1ns/1ps
module dtm_channel (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Sync reset, active high
    input wire logic resultValid, // New reading pulse
    input wire logic [7:0] resultData, // New reading
    input wire logic [7:0] highLimit, // High limit
    input wire logic [7:0] lowLimit, // Low limit
    input wire logic [7:0] overheatLimit, // Overheat limit
    input wire logic clearLow, // W1C strobe, low bit
    input wire logic clearHigh, // W1C strobe, high bit
    input wire logic clearOver, // W1C strobe, overheat bit
    output logic [7:0] reading, // Stored reading
    output logic lowExceeded, // Sticky low status
    output logic highExceeded, // Sticky high status
    output logic overExceeded // Sticky overheat status
);
    logic isLow;
    logic isHigh;
    logic isOver;

    // Signed compares on the newly converted value
    assign isLow = resultValid && ($signed(resultData) < $signed(lowLimit));
    assign isHigh = resultValid && ($signed(resultData) > $signed(highLimit));
    assign isOver = resultValid && ($signed(resultData) > $signed(overheatLimit));

    // Latest reading, overwritten only by a finished conversion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reading <= dtm_pkg::RST_READING;
        end else if (resultValid) begin
            reading <= resultData;
        end
    end

    // Sticky status; a new hit wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lowExceeded <= 1'b0;
            highExceeded <= 1'b0;
            overExceeded <= 1'b0;
        end else begin
            lowExceeded <= isLow || (lowExceeded && !clearLow);
            highExceeded <= isHigh || (highExceeded && !clearHigh);
            overExceeded <= isOver || (overExceeded && !clearOver);
        end
    end
endmodule : dtm_channel

// [hw/dtm_converter.sv]
`timescale 1ns/1ps
module dtm_converter #(
    parameter int NUM_CH = 3
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Sync reset, active high
    input wire logic run, // Conversion allowed
    input wire logic [NUM_CH-1:0] chanEnable, // Per-channel enable
    input wire logic adcDone, // Converter done, async pin
    input wire logic [7:0] adcData, // Converter result, async pins
    output logic adcReq, // Conversion request
    output logic [1:0] adcSel, // Diode select
    output logic resultValid, // One-cycle result pulse
    output logic [1:0] resultChan, // Channel of result
    output logic [7:0] resultData // Result value
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_RELEASE = 3'b100
    } dtm_conv_state_t;

    dtm_conv_state_t state;
    logic doneMeta;
    logic doneSync;
    logic [7:0] dataMeta;
    logic [7:0] dataSync;
    logic [1:0] next_sel;

    assign next_sel = (adcSel == 2'(NUM_CH - 1)) ? 2'h0 : 2'(adcSel + 2'h1);

    // Two-stage synchronisers for the converter handshake and data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            doneMeta <= 1'b0;
            doneSync <= 1'b0;
            dataMeta <= 8'h00;
            dataSync <= 8'h00;
        end else begin
            doneMeta <= adcDone;
            doneSync <= doneMeta;
            dataMeta <= adcData;
            dataSync <= dataMeta;
        end
    end

    // Round-robin sequencer over enabled channels
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= ST_IDLE;
            adcReq <= 1'b0;
            adcSel <= 2'h0;
            resultValid <= 1'b0;
            resultChan <= 2'h0;
            resultData <= 8'h00;
        end else begin
            resultValid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (run && !doneSync) begin
                        if (chanEnable[adcSel]) begin
                            adcReq <= 1'b1;
                            state <= ST_CONVERT;
                        end else begin
                            adcSel <= next_sel;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (!run) begin
                        adcReq <= 1'b0;
                        state <= ST_RELEASE;
                    end else if (doneSync) begin
                        adcReq <= 1'b0;
                        resultValid <= 1'b1;
                        resultChan <= adcSel;
                        resultData <= dataSync;
                        state <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!doneSync) begin
                        adcSel <= next_sel;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    adcReq <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : dtm_converter

// [hw/dtm_top.sv]
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dtm_top (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic reset, // Sync reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped access
    input wire logic sleepStateIn, // Sleep-state pin, high = active
    input wire logic adcDone, // Converter done pin
    input wire logic [7:0] adcData, // Converter result pins
    output logic adcReq, // Converter request
    output logic [1:0] adcSel, // Diode select
    output logic [2:0] overheatShutdownOut, // Shutdown, per sensor or combined
    output logic alarmOut, // Window alarm
    output logic sysMgmtInterrupt, // SYS_MGMT_INTERRUPT output
    output logic irqOut // IRQ output
);
    localparam int NCH = dtm_pkg::NUM_CH;
    localparam int EW = dtm_pkg::EVT_WIDTH;

    // Register state
    logic [EW-1:0] thermalEventStatus;
    logic [EW-1:0] thermalEventSmiRoute;
    logic [EW-1:0] thermalEventIrqRoute;
    logic [1:0] thermalConfig;
    logic [1:0] thermalBankSelect;
    logic [NCH-1:0] chEnable;
    logic [NCH-1:0] chAlarmEn;
    logic [NCH-1:0] chShutEn;
    logic [NCH-1:0] chLow;
    logic [NCH-1:0] chHigh;
    logic [NCH-1:0] chOver;

    // Per-channel limits and readings
    logic [7:0] channelTempHighLimit [NCH];
    logic [7:0] channelTempLowLimit [NCH];
    logic [7:0] channelOverheatLimit [NCH];
    logic [7:0] channelTempReading [NCH];

    // Sleep and wake-up
    logic sleepMeta;
    logic sleepSync;
    logic [7:0] wakeCount;
    logic awake;
    logic convRun;

    // Converter results
    logic resultValid;
    logic [1:0] resultChan;
    logic [7:0] resultData;

    // Bus decode
    logic access;
    logic wrTake;
    logic [3:0] idx;
    logic aligned;
    logic bankOk;
    logic [31:0] readValue;
    logic readHit;

    // Per-channel summaries
    logic [EW-1:0] next_events;
    logic [NCH-1:0] shutPerCh;
    logic [NCH-1:0] alarmPerCh;

    // Sleep pin synchroniser
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sleepMeta <= 1'b0;
            sleepSync <= 1'b0;
        end else begin
            sleepMeta <= sleepStateIn;
            sleepSync <= sleepMeta;
        end
    end

    // Wake-up sequence after the sleep input turns active again
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wakeCount <= 8'h00;
            awake <= 1'b0;
        end else if (!sleepSync) begin
            wakeCount <= 8'h00;
            awake <= 1'b0;
        end else if (!awake) begin
            // Count out the wake-up delay
            if (wakeCount == 8'(dtm_pkg::WAKE_CYCLES - 1)) begin
                awake <= 1'b1;
            end else begin
                wakeCount <= 8'(wakeCount + 8'h01);
            end
        end
    end

    // Registers are never reset by sleep, only halted
    assign convRun = awake && !thermalConfig[dtm_pkg::CONFIG_STANDBY_BIT];

    // Conversion sequencer
    dtm_converter #(
        .NUM_CH(NCH)
    ) u_conv (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(convRun),
        .chanEnable(chEnable),
        .adcDone(adcDone),
        .adcData(adcData),
        .adcReq(adcReq),
        .adcSel(adcSel),
        .resultValid(resultValid),
        .resultChan(resultChan),
        .resultData(resultData)
    );

    // APB decode
    assign access = psel && penable;
    assign wrTake = access && pready && pwrite;

    // Word index, legal when aligned
    assign idx = paddr[5:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);

    // Bank 3 selects no channel
    assign bankOk = thermalBankSelect < 2'(NCH);

    // Per-channel registers and limit logic
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic bankWr;
            logic cfgWr;

            // Writes reach the selected bank
            assign bankWr = wrTake && aligned && (thermalBankSelect == 2'(c));
            assign cfgWr = bankWr && (idx == dtm_pkg::IDX_CH_CFG_STATUS);

            // Channel enables and output enables
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    chEnable[c] <= 1'b0;
                    chAlarmEn[c] <= 1'b0;
                    chShutEn[c] <= 1'b0;
                end else if (cfgWr) begin
                    chEnable[c] <= pwdata[dtm_pkg::CFG_ENABLE_BIT];
                    chAlarmEn[c] <= pwdata[dtm_pkg::CFG_ALARM_EN_BIT];
                    chShutEn[c] <= pwdata[dtm_pkg::CFG_SHUT_EN_BIT];
                end
            end

            // Limits, programmed per channel
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    channelTempHighLimit[c] <= dtm_pkg::RST_HIGH;
                    channelTempLowLimit[c] <= dtm_pkg::RST_LOW;
                    channelOverheatLimit[c] <= dtm_pkg::RST_OVERHEAT;
                end else if (bankWr) begin
                    if (idx == dtm_pkg::IDX_CH_HIGH) begin
                        channelTempHighLimit[c] <= pwdata[7:0];
                    end
                    if (idx == dtm_pkg::IDX_CH_LOW) begin
                        channelTempLowLimit[c] <= pwdata[7:0];
                    end
                    if (idx == dtm_pkg::IDX_CH_OVERHEAT) begin
                        channelOverheatLimit[c] <= pwdata[7:0];
                    end
                end
            end

            // Compare and sticky status
            dtm_channel u_chan (
                .clk_sys(clk_sys),
                .reset(reset),
                .resultValid(resultValid && resultChan == 2'(c)),
                .resultData(resultData),
                .highLimit(channelTempHighLimit[c]),
                .lowLimit(channelTempLowLimit[c]),
                .overheatLimit(channelOverheatLimit[c]),
                .clearLow(cfgWr && pwdata[dtm_pkg::CFG_LOW_BIT]),
                .clearHigh(cfgWr && pwdata[dtm_pkg::CFG_HIGH_BIT]),
                .clearOver(cfgWr && pwdata[dtm_pkg::CFG_OVER_BIT]),
                .reading(channelTempReading[c]),
                .lowExceeded(chLow[c]),
                .highExceeded(chHigh[c]),
                .overExceeded(chOver[c])
            );

            // Event pair: alarm at even bit, overheat at odd bit
            assign next_events[2*c] = chLow[c] || chHigh[c];
            assign next_events[2*c+1] = chOver[c];
            assign shutPerCh[c] = chShutEn[c] && chOver[c];
            assign alarmPerCh[c] = chAlarmEn[c] && (chLow[c] || chHigh[c]);
        end
    endgenerate

    // Shared control registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            thermalEventSmiRoute <= '0;
            thermalEventIrqRoute <= '0;
            thermalConfig <= dtm_pkg::RST_CONFIG;
            thermalBankSelect <= dtm_pkg::RST_BANK;
        end else if (wrTake && aligned) begin
            case (idx)
                dtm_pkg::IDX_SMI_ROUTE: thermalEventSmiRoute <= pwdata[EW-1:0];
                dtm_pkg::IDX_IRQ_ROUTE: thermalEventIrqRoute <= pwdata[EW-1:0];
                dtm_pkg::IDX_CONFIG: thermalConfig <= pwdata[1:0];
                dtm_pkg::IDX_BANK_SEL: thermalBankSelect <= pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux: shared low offsets, banked upper offsets
    always_comb begin
        readValue = 32'h0000_0000;
        readHit = aligned;
        case (idx)
            dtm_pkg::IDX_EVT_STATUS: readValue[EW-1:0] = thermalEventStatus;
            dtm_pkg::IDX_SMI_ROUTE: readValue[EW-1:0] = thermalEventSmiRoute;
            dtm_pkg::IDX_IRQ_ROUTE: readValue[EW-1:0] = thermalEventIrqRoute;
            dtm_pkg::IDX_CONFIG: readValue[1:0] = thermalConfig;
            dtm_pkg::IDX_BANK_SEL: readValue[1:0] = thermalBankSelect;
            dtm_pkg::IDX_CH_CFG_STATUS, dtm_pkg::IDX_CH_READING, dtm_pkg::IDX_CH_HIGH,
            dtm_pkg::IDX_CH_LOW, dtm_pkg::IDX_CH_OVERHEAT: begin
                // No channel behind bank 3
                if (!bankOk) begin
                    readHit = 1'b0;
                end else if (idx == dtm_pkg::IDX_CH_CFG_STATUS) begin
                    readValue[dtm_pkg::CFG_ENABLE_BIT] = chEnable[thermalBankSelect];
                    readValue[dtm_pkg::CFG_LOW_BIT] = chLow[thermalBankSelect];
                    readValue[dtm_pkg::CFG_HIGH_BIT] = chHigh[thermalBankSelect];
                    readValue[dtm_pkg::CFG_OVER_BIT] = chOver[thermalBankSelect];
                    readValue[dtm_pkg::CFG_ALARM_EN_BIT] = chAlarmEn[thermalBankSelect];
                    readValue[dtm_pkg::CFG_SHUT_EN_BIT] = chShutEn[thermalBankSelect];
                end else if (idx == dtm_pkg::IDX_CH_READING) begin
                    readValue[7:0] = channelTempReading[thermalBankSelect];
                end else if (idx == dtm_pkg::IDX_CH_HIGH) begin
                    readValue[7:0] = channelTempHighLimit[thermalBankSelect];
                end else if (idx == dtm_pkg::IDX_CH_LOW) begin
                    readValue[7:0] = channelTempLowLimit[thermalBankSelect];
                end else begin
                    readValue[7:0] = channelOverheatLimit[thermalBankSelect];
                end
            end
            default: readHit = 1'b0;
        endcase
    end

    // APB answer: one wait state, data and error from flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            // Latched in the first access cycle
            if (access && !pready) begin
                prdata <= (readHit && !pwrite) ? readValue : 32'h0000_0000;
                pslverr <= !readHit;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Event summary follows channel status
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            thermalEventStatus <= '0;
        end else begin
            thermalEventStatus <= next_events;
        end
    end

    // System outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overheatShutdownOut <= 3'h0;
            alarmOut <= 1'b0;
            sysMgmtInterrupt <= 1'b0;
            irqOut <= 1'b0;
        end else begin
            if (thermalConfig[dtm_pkg::CONFIG_COMBINED_BIT]) begin
                overheatShutdownOut <= {3{|shutPerCh}};
            end else begin
                overheatShutdownOut <= shutPerCh;
            end
            alarmOut <= |alarmPerCh;
            // Interrupts through route masks
            sysMgmtInterrupt <= |(thermalEventStatus & thermalEventSmiRoute);
            irqOut <= |(thermalEventStatus & thermalEventIrqRoute);
        end
    end
endmodule : dtm_top

// [test/dtm_top_props.sv]
`timescale 1ns/1ps
module dtm_top_props (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic adcDone, // Done
    input wire logic adcReq, // Request
    input wire logic [1:0] adcSel, // Diode
    input wire logic [2:0] overheatShutdownOut, // Shutdown
    input wire logic alarmOut, // Alarm
    input wire logic sysMgmtInterrupt, // SYS_MGMT_INTERRUPT
    input wire logic irqOut // IRQ
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Bus phases and converter steps
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    sequence s_answer; !pready ##1 pready; endsequence
    property p_one_wait; s_setup ##1 s_access |-> s_answer; endproperty
    property p_ready_once; pready |=> !pready; endproperty
    property p_data_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    property p_err_qual; pslverr |-> pready; endproperty
    property p_reset_quiet;
        $fell(reset) |-> !alarmOut && !irqOut && !sysMgmtInterrupt && overheatShutdownOut == 3'h0 && !adcReq;
    endproperty
    property p_req_gap; $rose(adcReq) |-> !$past(adcDone, 2) && !$past(adcDone, 3); endproperty
    property p_sel_hold; adcReq && $past(adcReq) |-> $stable(adcSel); endproperty
    property p_req_drop; $rose(adcDone) && adcReq |-> ##[1:4] !adcReq; endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not in second access cycle");
    a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
    a_data_idle: assert property (p_data_idle) else $error("read data outside ready");
    a_err_qual: assert property (p_err_qual) else $error("error without ready");
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
    a_req_gap: assert property (p_req_gap) else $error("request before done low");
    a_sel_hold: assert property (p_sel_hold) else $error("diode select moved in conversion");
    a_req_drop: assert property (p_req_drop) else $error("request held after done");
endmodule : dtm_top_props

bind dtm_top dtm_top_props i_dtm_top_props (.clk_sys, .reset, .psel, .penable, .prdata, .pready, .pslverr,
    .adcDone, .adcReq, .adcSel, .overheatShutdownOut, .alarmOut, .sysMgmtInterrupt, .irqOut);

// [test/dtm_adc_model.sv]
`timescale 1ns/1ps
module dtm_adc_model (
    input wire logic clk_sys, // Clock
    input wire logic adcReq, // Request
    input wire logic [1:0] adcSel, // Diode
    input wire logic [23:0] temps, // Diode temperatures, channel 0 low
    output logic adcDone, // Done level
    output logic [7:0] adcData // Result
);
    int waitCnt = 0;
    // Idle at time zero
    initial begin
        adcDone = 1'b0;
        adcData = 8'h00;
    end
    // Four-phase answer, slower for higher channels
    always @(posedge clk_sys) begin
        if (!adcReq) begin
            waitCnt <= 0;
            if (adcDone) begin
                adcDone <= 1'b0;
                adcData <= ~adcData; // Released bus holds no stale value
            end
        end else if (!adcDone) begin
            waitCnt <= waitCnt + 1;
            if (waitCnt == 1) adcData <= temps[adcSel * 8 +: 8];
            if (waitCnt == 2 + 6 * adcSel) adcDone <= 1'b1;
        end
    end
endmodule : dtm_adc_model

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, errSeen;
    logic sleepStateIn, adcDone, adcReq, alarmOut, sysMgmtInterrupt, irqOut;
    logic [7:0] paddr, adcData;
    logic [31:0] pwdata, prdata, rdData;
    logic [1:0] adcSel;
    logic [2:0] overheatShutdownOut;
    logic [23:0] temps;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    dtm_top i_dtm_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleepStateIn, .adcDone, .adcData, .adcReq, .adcSel, .overheatShutdownOut, .alarmOut,
        .sysMgmtInterrupt, .irqOut);
    dtm_adc_model i_dtm_adc_model (.clk_sys, .adcReq, .adcSel, .temps, .adcDone, .adcData);

    // Clock, 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer by register index
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rdData, {24'h00_0000, exp});
    endtask : rdChk

    // Poll the reading of the selected bank
    task automatic waitRd(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, 4'hB, 8'h00);
            n++;
        end while (rdData !== {24'h00_0000, exp} && n < 300);
        check(rdData, {24'h00_0000, exp});
    endtask : waitRd

    // Pins as alarm, shutdown[2:0], SYS_MGMT_INTERRUPT, IRQ
    task automatic outs(input logic [5:0] exp);
        repeat (3) @(posedge clk_sys);
        check(32'({alarmOut, overheatShutdownOut, sysMgmtInterrupt, irqOut}), 32'(exp));
    endtask : outs

    task automatic setCh(input logic [7:0] ch, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ov);
        apb(1'b1, 4'h9, ch);
        apb(1'b1, 4'hC, hi);
        apb(1'b1, 4'hD, lo);
        apb(1'b1, 4'hE, ov);
        apb(1'b1, 4'hA, 8'h31);
    endtask : setCh

    task automatic t_reset();
        rdChk(4'h9, 8'h00);
        rdChk(4'hC, dtm_pkg::RST_HIGH);
        rdChk(4'hD, dtm_pkg::RST_LOW);
        rdChk(4'hB, 8'h00);
        apb(1'b0, 4'h1, 8'h00);
        check(32'(errSeen), 32'h0000_0001);
        apb(1'b1, 4'h2, 8'h2A);
        apb(1'b1, 4'h9, 8'h02);
        rdChk(4'h2, 8'h2A);
        rdChk(4'h9, 8'h02);
        apb(1'b1, 4'h9, 8'h03);
        apb(1'b0, 4'hB, 8'h00);
        check(32'(errSeen), 32'h0000_0001);
    endtask : t_reset

    task automatic t_limits();
        setCh(8'h00, 8'h3C, 8'hC9, 8'h46);
        setCh(8'h01, 8'h7F, 8'h05, 8'h7F);
        setCh(8'h02, 8'h7F, 8'hC9, 8'h7F);
        waitRd(8'h19);
        rdChk(4'hA, 8'h31);
        apb(1'b1, 4'h9, 8'h01);
        waitRd(8'hE7);
        rdChk(4'hA, 8'h33);
        apb(1'b1, 4'h9, 8'h00);
        waitRd(8'h50);
        rdChk(4'hA, 8'h3D);
        rdChk(4'h0, 8'h07);
        outs(6'b1_001_10);
        apb(1'b1, 4'h4, 8'h20);
        outs(6'b1_001_10);
        apb(1'b1, 4'h4, 8'h04);
        apb(1'b1, 4'h8, 8'h02);
        outs(6'b1_111_11);
    endtask : t_limits

    task automatic t_sticky();
        temps <= 24'h19_1919;
        waitRd(8'h19);
        rdChk(4'hA, 8'h3D);
        apb(1'b1, 4'hA, 8'h31);
        rdChk(4'hA, 8'h3D);
        apb(1'b1, 4'hA, 8'h3F);
        rdChk(4'hA, 8'h31);
        rdChk(4'h0, 8'h04);
        outs(6'b1_000_01);
        apb(1'b1, 4'h9, 8'h01);
        apb(1'b1, 4'hA, 8'h33);
        outs(6'b0_000_00);
    endtask : t_sticky

    task automatic t_halt();
        apb(1'b1, 4'h8, 8'h03);
        temps <= 24'h19_2D19;
        repeat (400) @(posedge clk_sys);
        rdChk(4'hB, 8'h19);
        rdChk(4'hD, 8'h05);
        sleepStateIn <= 1'b0;
        apb(1'b1, 4'h8, 8'h02);
        repeat (400) @(posedge clk_sys);
        rdChk(4'hB, 8'h19);
        rdChk(4'h8, 8'h02);
        sleepStateIn <= 1'b1;
        waitRd(8'h2D);
    endtask : t_halt

    // Reset, then the scenarios
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sleepStateIn = 1'b1;
        temps = 24'h19_E750;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_limits();
        t_sticky();
        t_halt();
        stop_test();
    end
endmodule : tb
